// File: hw/wps_sequencer.sv
// Wake-on-stimulus power sequencer: wake capture, boost and supply sequencing.
// Assumes comparator levels for rail-good and cap-half, and an async pin world.
`timescale 1ns/1ps

// What this block does
// - Boost stays off in standby; a wake stimulus starts boosting the rail.
// - Main supply switches on only after the rail reports power-good.
// - Main supply output stays off while in standby.
// - A low level on the wake input is a wake stimulus.
// - Serial receive activity in standby wakes the main supply.
// - After the wake, serial receive levels pass to the host unchanged.
// - A low sensor trigger pulse switches the sensor supply on.
// - Sensor supply switches off once the timing cap reaches half rail.
// - Blocked-detect is sampled just before the sensor supply goes off.
// - Sampled high blocked-detect wakes; low does nothing.
// - Host sets auxiliary supplies freely and can remove main supply.
// - A wake power-up pulls the interrupt line low.
// - Further wakes while running pull the interrupt line low again.
// - Main-off leaves auxiliary supplies in their selected state.
module wps_sequencer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wake_in_a_n,
    input wire logic serial_rx_from_line,
    input wire logic sensor_cycle_trigger_n,
    input wire logic sensor_ontime_cap,
    input wire logic blocked_detect,
    input wire logic rail_power_good,
    input wire logic main_supply_off_n,
    input wire logic aux_supply_a_ctrl,
    input wire logic aux_supply_b_ctrl,
    input wire logic int_ack_in,
    output logic boost_enable,
    output logic main_supply_out,
    output logic sensor_supply_out,
    output logic serial_rx_to_host,
    output logic aux_supply_a_out,
    output logic aux_supply_b_out,
    output logic int_ack_out,
    output logic int_ack_oe
);
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] raw_v, sync_v;
    assign raw_v = {wake_in_a_n, serial_rx_from_line, sensor_cycle_trigger_n,
                    sensor_ontime_cap, blocked_detect, rail_power_good,
                    main_supply_off_n, aux_supply_a_ctrl, aux_supply_b_ctrl, int_ack_in};
    // Pins that idle high reset high, so no false edge, wake or aux glitch follows reset.
    localparam logic [NSYNC-1:0] SYNC_RST = 10'h389;

    // Each pin is brought into the clock domain before use.
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        wps_sync_if sif ();
        assign sif.raw = raw_v[i];
        assign sync_v[i] = sif.sync;
        wps_sync2 #(.RST_VAL(SYNC_RST[i])) u_sync (
            .clk(clk),
            .sys_rst(sys_rst),
            .s(sif)
        );
    end

    logic wake_n_s, rx_s, trig_n_s, cap_s, blk_s, pgood_s, off_n_s, aux_a_s, aux_b_s, ack_s;
    assign {wake_n_s, rx_s, trig_n_s, cap_s, blk_s, pgood_s, off_n_s, aux_a_s, aux_b_s,
            ack_s} = sync_v;
    logic aux_b_q;

    wps_pkg::wps_state_e state_q, state_d;
    logic [15:0] settle_q, settle_d;
    logic rx_prev_q, rx_prev_d, trig_prev_q, trig_prev_d;
    logic sens_q, sens_d, blk_wake_q, blk_wake_d;
    logic irq_q, irq_d, main_q, main_d, boost_q, boost_d, rxo_q, rxo_d;
    logic aux_a_q, aux_a_d, aux_b_d;
    logic wake_ev, rx_edge, trig_fall, ack_rise, ack_prev_q, ack_prev_d;

    always_comb begin
        rx_edge = rx_prev_q != rx_s;
        trig_fall = trig_prev_q && !trig_n_s;
        ack_rise = !ack_prev_q && ack_s;
        // Serial wakes count only in standby; later traffic is plain data.
        wake_ev = !wake_n_s || blk_wake_q
                  || (rx_edge && state_q == wps_pkg::WPS_STANDBY);
        rx_prev_d = rx_s;
        ack_prev_d = ack_s;
        trig_prev_d = trig_n_s;
        state_d = state_q;
        settle_d = settle_q;
        boost_d = boost_q;
        main_d = main_q;
        irq_d = irq_q;
        sens_d = sens_q;
        blk_wake_d = 1'b0;
        rxo_d = rx_s;
        aux_a_d = aux_a_s;
        aux_b_d = aux_b_s;
        if (trig_fall) begin
            sens_d = 1'b1;
        end else if (sens_q && cap_s) begin
            sens_d = 1'b0;
            blk_wake_d = blk_s;
        end
        // Acknowledge releases the line; a new wake in that cycle wins.
        if (ack_rise) begin
            irq_d = 1'b0;
        end
        case (state_q)
            wps_pkg::WPS_STANDBY: begin
                boost_d = 1'b0;
                main_d = 1'b0;
                if (wake_ev) begin
                    state_d = wps_pkg::WPS_BOOST;
                    boost_d = 1'b1;
                    settle_d = 16'h0000;
                    irq_d = 1'b1;
                end
            end
            wps_pkg::WPS_BOOST: begin
                if (wake_ev) begin
                    irq_d = 1'b1;
                end
                if (pgood_s && settle_q >= 16'(wps_pkg::BOOST_SETTLE_CYC - 1)) begin
                    state_d = wps_pkg::WPS_MAIN_ON;
                    main_d = 1'b1;
                end else if (!pgood_s) begin
                    settle_d = 16'h0000;
                end else begin
                    settle_d = settle_q + 16'h0001;
                end
            end
            wps_pkg::WPS_MAIN_ON: begin
                // Wakes here only interrupt; the supply is left untouched.
                if (wake_ev) begin
                    irq_d = 1'b1;
                end
                if (!off_n_s) begin
                    state_d = wps_pkg::WPS_SHUTDOWN;
                    main_d = 1'b0;
                end
            end
            wps_pkg::WPS_SHUTDOWN: begin
                boost_d = 1'b0;
                irq_d = 1'b0;
                // Hold here until the host's off request has been released.
                if (off_n_s) begin
                    state_d = wps_pkg::WPS_STANDBY;
                end
            end
            default: begin
                state_d = wps_pkg::WPS_STANDBY;
                boost_d = 1'b0;
                main_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= wps_pkg::WPS_STANDBY;
            settle_q <= 16'h0000;
            rx_prev_q <= 1'b1;
            trig_prev_q <= 1'b1;
            ack_prev_q <= 1'b1;
            sens_q <= wps_pkg::sensor_off_rst;
            blk_wake_q <= 1'b0;
            irq_q <= 1'b0;
            main_q <= 1'b0;
            boost_q <= 1'b0;
            rxo_q <= 1'b1;
            aux_a_q <= 1'b0;
            aux_b_q <= 1'b0;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
            rx_prev_q <= rx_prev_d;
            trig_prev_q <= trig_prev_d;
            ack_prev_q <= ack_prev_d;
            sens_q <= sens_d;
            blk_wake_q <= blk_wake_d;
            irq_q <= irq_d;
            main_q <= main_d;
            boost_q <= boost_d;
            rxo_q <= rxo_d;
            aux_a_q <= aux_a_d;
            aux_b_q <= aux_b_d;
        end
    end

    assign boost_enable = boost_q;
    assign main_supply_out = main_q;
    assign sensor_supply_out = sens_q;
    assign serial_rx_to_host = rxo_q;
    assign aux_supply_a_out = aux_a_q;
    assign aux_supply_b_out = aux_b_q;
    // The interrupt line is open-drain: driven low only while pending.
    assign int_ack_out = 1'b0;
    assign int_ack_oe = irq_q;

    main_gated_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(main_supply_out) |-> $past(state_q) == wps_pkg::WPS_BOOST && $past(pgood_s))
        else $error("Main supply rose without rail power-good.");
    standby_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == wps_pkg::WPS_STANDBY |-> !main_supply_out)
        else $error("Main supply on in standby.");
    wake_boost_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == wps_pkg::WPS_STANDBY && !wake_n_s |=> boost_enable && int_ack_oe)
        else $error("Wake did not start boost and interrupt.");
    rx_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 serial_rx_to_host == $past(rx_s))
        else $error("Serial data not forwarded.");
    sensor_on_a: assert property (@(posedge clk) disable iff (sys_rst)
        trig_fall |=> sensor_supply_out)
        else $error("Sensor supply did not switch on.");
    sensor_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        sensor_supply_out && cap_s && !trig_fall |=> !sensor_supply_out)
        else $error("Sensor supply did not switch off.");
    blk_wake_a: assert property (@(posedge clk) disable iff (sys_rst)
        sensor_supply_out && cap_s && !trig_fall && blk_s |=> ##1 int_ack_oe)
        else $error("Blocked sample did not wake.");
    no_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == wps_pkg::WPS_MAIN_ON && off_n_s |=> main_supply_out && boost_enable)
        else $error("Main supply dropped while running.");
    rewake_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == wps_pkg::WPS_MAIN_ON && !wake_n_s |=> int_ack_oe)
        else $error("Running wake gave no interrupt.");
    off_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == wps_pkg::WPS_MAIN_ON && !off_n_s |=> !main_supply_out
        ##1 aux_supply_a_out == $past(aux_a_s))
        else $error("Main-off failed or disturbed auxiliary.");
    ack_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        ack_rise && !wake_ev |=> !int_ack_oe)
        else $error("Acknowledge did not release the line.");
endmodule

// File: pkg/wps_pkg.sv
// Package for the wake-on-stimulus power sequencer: states and timing counts.
// Assumes a 100 MHz clock; analog thresholds arrive as comparator levels.
package wps_pkg;
    localparam int CLK_MHZ = 100;
    // Least settle time of the boost rail before the main supply may switch on.
    localparam int BOOST_SETTLE_US = 10;
    localparam int BOOST_SETTLE_CYC = BOOST_SETTLE_US * CLK_MHZ;
    localparam logic sensor_off_rst = 1'b0;

    typedef enum logic [3:0] {
        WPS_STANDBY = 4'h1,
        WPS_BOOST = 4'h2,
        WPS_MAIN_ON = 4'h4,
        WPS_SHUTDOWN = 4'h8
    } wps_state_e;
endpackage

// File: pkg/wps_sync_if.sv
// Interface carrying one raw asynchronous level and its synchronised copy.
// Assumes the raw level comes from a pin outside the clock domain.
`timescale 1ns/1ps
interface wps_sync_if;
    logic raw;
    logic sync;
    modport sink (input raw, output sync);
    modport src (output raw, input sync);
endinterface

// File: hw/wps_sync2.sv
// Two flip-flop synchroniser for one asynchronous level.
// Assumes clk is the sequencer clock and sys_rst is synchronous.
`timescale 1ns/1ps
module wps_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    wps_sync_if.sink s
);
    logic meta_q, meta_d, sync_q, sync_d;

    always_comb begin
        meta_d = s.raw;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign s.sync = sync_q;
endmodule

// File: verification/wps_host_model.sv
// Host-side partner: wake sources on the shared wake line, boost rail, ack pin.
// Assumes bench requests change just after the rising clock edge.
`timescale 1ns/1ps
module wps_host_model #(
    parameter int RAIL_RISE = 50
) (
    input wire logic clk,
    input wire logic alarm_req,
    input wire logic switch_req,
    input wire logic ack_req,
    input wire logic boost_enable,
    input wire logic int_ack_out,
    input wire logic int_ack_oe,
    output logic wake_in_a_n,
    output logic rail_power_good,
    output logic int_ack_in
);
    int rise_cnt = 0;
    // Sources only pull the shared line low, so no source can mask another.
    assign wake_in_a_n = !(alarm_req || switch_req);
    // The host pin drives high to acknowledge; otherwise the pull-up holds it high unless the sequencer drives it low.
    assign int_ack_in = ack_req ? 1'b1 : (int_ack_oe ? int_ack_out : 1'b1);
    always @(posedge clk) begin
        if (!boost_enable)
            rise_cnt <= 0;
        else if (rise_cnt < RAIL_RISE)
            rise_cnt <= rise_cnt + 1;
    end
    // The rail needs time to rise, so power-good lags the boost start.
    assign rail_power_good = boost_enable && (rise_cnt == RAIL_RISE);
endmodule

// File: verification/test_wps_sequencer.sv
// Self-checking bench for the power sequencer with the host partner model.
// Assumes the sequencer's registered outputs settle before the falling edge.
`timescale 1ns/1ps
module test_wps_sequencer;
    logic clk = 0, sys_rst = 1, alarm_req = 0, switch_req = 0, ack_req = 0;
    logic serial_rx = 1, trig_n = 1, cap = 0, blocked = 0, off_n = 1, aux_a = 0, aux_b = 0;
    logic wake_n, pgood, ack_in, boost, main_on, sensor, rx_host, aux_a_o, aux_b_o, ia_o, ia_oe;
    logic [2:0] last_obs = 3'h0, exp_q[$];
    string name_q[$];
    int miscompares = 0, samples_checked = 0;
    logic [31:0] rng = 32'h00000054;
    wps_sequencer uut (.clk(clk), .sys_rst(sys_rst), .wake_in_a_n(wake_n),
        .serial_rx_from_line(serial_rx), .sensor_cycle_trigger_n(trig_n),
        .sensor_ontime_cap(cap), .blocked_detect(blocked), .rail_power_good(pgood),
        .main_supply_off_n(off_n), .aux_supply_a_ctrl(aux_a), .aux_supply_b_ctrl(aux_b),
        .int_ack_in(ack_in), .boost_enable(boost), .main_supply_out(main_on),
        .sensor_supply_out(sensor), .serial_rx_to_host(rx_host), .aux_supply_a_out(aux_a_o),
        .aux_supply_b_out(aux_b_o), .int_ack_out(ia_o), .int_ack_oe(ia_oe));
    wps_host_model host (.clk(clk), .alarm_req(alarm_req), .switch_req(switch_req),
        .ack_req(ack_req), .boost_enable(boost), .int_ack_out(ia_o), .int_ack_oe(ia_oe),
        .wake_in_a_n(wake_n), .rail_power_good(pgood), .int_ack_in(ack_in));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic note(input string what, input logic [2:0] exp);
        name_q.push_back(what);
        exp_q.push_back(exp);
    endtask
    task automatic wait_main(input logic want);
        int n;
        n = 0;
        while (main_on !== want && n < 1500) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic ack();
        note("ack {main,sensor,irq}", 3'h4);
        ack_req <= 1'b1;
        cyc(5);
        ack_req <= 1'b0;
        cyc(1);
    endtask
    task automatic power_up();
        cyc(4);
        check("boost", {2'h0, boost}, 3'h1);
        cyc(20);
        check("main early", {2'h0, main_on}, 3'h0);
        note("main on", 3'h5);
        wait_main(1'b1);
        ack();
    endtask
    task automatic main_off();
        note("main off", 3'h0);
        off_n <= 1'b0;
        cyc(5);
        off_n <= 1'b1;
        cyc(5);
        check("boost idle", {2'h0, boost}, 3'h0);
    endtask
    always @(negedge clk) begin
        if (!sys_rst && {main_on, sensor, ia_oe} !== last_obs) begin
            if (exp_q.size() == 0)
                check("unexpected change", {main_on, sensor, ia_oe}, last_obs);
            else
                check(name_q.pop_front(), {main_on, sensor, ia_oe}, exp_q.pop_front());
            last_obs = {main_on, sensor, ia_oe};
        end
    end
    initial begin
        cyc(30000);
        miscompares++;
        complete_run();
    end
    initial begin
        cyc(12);
        sys_rst <= 1'b0;
        check("standby main", {2'h0, main_on}, 3'h0);
        cyc(1);
        note("alarm irq", 3'h1);
        alarm_req <= 1'b1;
        cyc(2);
        alarm_req <= 1'b0;
        power_up();
        note("rewake irq", 3'h5);
        switch_req <= 1'b1;
        cyc(2);
        switch_req <= 1'b0;
        cyc(10);
        check("boost kept", {2'h0, boost}, 3'h1);
        check("ack pulled low", {1'h0, ia_oe, ia_o}, 3'h2);
        ack();
        for (int i = 0; i < 6; i++) begin
            rng = xorshift(rng);
            serial_rx <= rng[0];
            aux_a <= rng[1];
            aux_b <= rng[2];
            cyc(4);
            check("rx pass", {2'h0, rx_host}, {2'h0, rng[0]});
            check("aux", {1'h0, aux_a_o, aux_b_o}, {1'h0, rng[1], rng[2]});
        end
        serial_rx <= 1'b1;
        cyc(4);
        main_off();
        check("aux kept", {1'h0, aux_a_o, aux_b_o}, {1'h0, rng[1], rng[2]});
        $display("test pin wake done");
        note("serial irq", 3'h1);
        serial_rx <= 1'b0;
        power_up();
        serial_rx <= 1'b1;
        main_off();
        $display("test serial wake done");
        for (int b = 0; b < 2; b++) begin
            note("sensor on", 3'h2);
            trig_n <= 1'b0;
            cyc(3);
            trig_n <= 1'b1;
            blocked <= b[0];
            cyc(5);
            note("sensor off", 3'h0);
            cap <= 1'b1;
            if (b == 1) begin
                note("sensor wake", 3'h1);
                cyc(4);
                blocked <= 1'b0;
                cap <= 1'b0;
                power_up();
                main_off();
            end else begin
                cyc(20);
                cap <= 1'b0;
                check("clear no wake", {2'h0, boost}, 3'h0);
            end
        end
        $display("test sensor done");
        cyc(10);
        check("notes left", exp_q.size() == 0 ? 3'h0 : 3'h7, 3'h0);
        complete_run();
    end
endmodule
